/* File: pdsg_defs.vh */
// Purpose: shared constants of the paged data address and stack guard
// Assumes: 32-bit AXI4-Lite register slave, 16-bit data addresses
// Notes:   definitions only
`ifndef PDSG_DEFS_VH
`define PDSG_DEFS_VH

// register byte offsets
`define PDSG_OFS_RD_PAGE    8'h00
`define PDSG_OFS_WR_PAGE    8'h04
`define PDSG_OFS_STK_LIMIT  8'h08
`define PDSG_OFS_STK_PTR    8'h0C
`define PDSG_OFS_STATUS     8'h10

// reset values
`define PDSG_RST_RD_PAGE    10'h001
`define PDSG_RST_WR_PAGE    9'h001
`define PDSG_RST_STK_PTR    16'h0800

// address layout
`define PDSG_EA_WIN_BIT     15
`define PDSG_RD_PVIEW_BIT   9
`define PDSG_RD_UPPER_BIT   8
`define PDSG_STK_FLOOR      16'h0800
`define PDSG_STK_STEP       16'h0002
`define PDSG_BASE_TOP       8'h00

// value masks of the bus-written registers
`define PDSG_MASK_RD_PAGE   32'h000003FF
`define PDSG_MASK_WR_PAGE   32'h000001FF
`define PDSG_MASK_WORD      32'h0000FFFE

// access cycle counts and the number of repeat head accesses
`define PDSG_CYC_PLAIN      2'd1
`define PDSG_CYC_WIN_RD     2'd2
`define PDSG_CYC_RPT_HEAD   2'd3
`define PDSG_RPT_HEAD_CNT   2'd2

// bus answers
`define PDSG_RESP_OKAY      2'b00
`define PDSG_RESP_SLVERR    2'b10

`endif

/* File: pdsg_guard.v */
// Purpose: extends 16-bit data addresses into a 24-bit paged space and
//          guards the software stack against overflow and underflow
// Assumes: one clock, asynchronous active-low reset, one access at a time
// Notes:   registers reached over AXI4-Lite; access answered by acc_done
`timescale 1ns/1ps
`include "pdsg_defs.vh"

// Functional notes
// R1: read page for reads, write page for writes
// R2: page plus 16-bit address gives 24 bits
// R3: program view reads use read page only
// R4: read window: 9 page bits, 15 address bits
// R5: write window: 9 page bits, 15 address bits
// R6: page zero window access raises address trap
// R7: addresses below 8000h map straight through
// R8: page registers never change on pointer rollover
// R9: window read takes one extra cycle
// R10: repeated window reads: 3,3 then 1 cycles
// R11: window writes finish in one cycle
// R12: software avoids read-modify-write under repeat
// R13: read-modify-write takes read page
// R14: window only when address bit 15 set
// R15: stack grows up, post-inc push, pre-dec pop
// R16: call push clears pushed top byte
// R17: exception push joins status byte with counter
// R18: stack limit unreset, bit 0 reads zero
// R19: push above limit raises stack trap
// R20: stack address below 0800h raises stack trap
// R21: software avoids stack read right after limit write
// R22: read page bit 9 selects program view
// R23: traps pulse one cycle, access suppressed
module pdsg_guard
(
  input  wire        clk_sys,
  input  wire        rst_b,
  // axi4-lite register slave
  input  wire [7:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [7:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  // cpu access request
  input  wire        acc_valid,
  output wire        acc_ready,
  input  wire        acc_write,
  input  wire        acc_rmw,
  input  wire        acc_repeat,
  input  wire        acc_push,
  input  wire        acc_pop,
  input  wire        acc_pc_call,
  input  wire        acc_pc_exc,
  input  wire [15:0] acc_addr,
  input  wire [15:0] acc_wdata,
  input  wire [7:0]  pc_high_byte,
  input  wire [7:0]  status_low_byte,
  output reg         acc_done,
  output reg         acc_fault,
  // memory side
  output reg         mem_valid,
  output reg         mem_write,
  output reg         mem_rmw,
  output reg  [23:0] mem_addr,
  output reg  [15:0] mem_wdata,
  output reg         mem_program_view,
  output reg         mem_program_upper,
  // trap requests toward exception logic
  output reg         trap_address_error,
  output reg         trap_stack_error
);

  localparam [1:0] ST_IDLE = 2'b01;
  localparam [1:0] ST_BUSY = 2'b10;

  reg  [9:0]  read_page_select;
  reg  [8:0]  write_page_select;
  reg  [15:0] stack_limit_value;
  reg  [15:0] software_stack_pointer;
  reg  [1:0]  state;
  reg  [1:0]  wait_cnt;
  reg  [1:0]  rpt_cnt;

  reg         aw_full;
  reg  [7:0]  aw_addr;
  reg         w_full;
  reg  [31:0] w_data;
  reg  [3:0]  w_strb;

  wire        take = acc_valid & state[0];
  wire        do_bus_wr = aw_full & w_full & ~s_axi_bvalid;
  wire        rd_take = s_axi_arvalid & ~s_axi_rvalid;

  assign acc_ready     = state[0];
  assign s_axi_awready = ~aw_full & ~s_axi_bvalid;
  assign s_axi_wready  = ~w_full & ~s_axi_bvalid;
  assign s_axi_arready = ~s_axi_rvalid;

  function [31:0] merge;
    input [31:0] old_v;
    input [31:0] new_v;
    input [3:0]  strb;
    integer i;
    begin
      merge = old_v;
      for (i = 0; i < 4; i = i + 1)
        if (strb[i])
          merge[i*8 +: 8] = new_v[i*8 +: 8];
    end
  endfunction

  // merged bus writes; cut to each register's width where stored
  wire [31:0] new_rd_page = merge({22'h0, read_page_select}, w_data,
                                  w_strb) & `PDSG_MASK_RD_PAGE;
  wire [31:0] new_wr_page = merge({23'h0, write_page_select}, w_data,
                                  w_strb) & `PDSG_MASK_WR_PAGE;
  wire [31:0] new_lim     = merge({16'h0000, stack_limit_value}, w_data,
                                  w_strb) & `PDSG_MASK_WORD;
  wire [31:0] new_sp      = merge({16'h0000, software_stack_pointer},
                                  w_data, w_strb) & `PDSG_MASK_WORD;

  // address generation and checks for the offered access
  reg  [15:0] ea;
  reg  [23:0] next_addr;
  reg         next_pview;
  reg         next_upper;
  reg         addr_err;
  reg         stk_err;
  reg  [1:0]  cycles;
  reg  [15:0] next_wdata;
  reg         is_rd;
  wire        win = ea[`PDSG_EA_WIN_BIT];
  wire [9:0]  page_sel = (acc_write & ~acc_rmw) ?
                         {1'b0, write_page_select} :
                         read_page_select;                  // R1 R13

  always @*
  begin
    is_rd      = ~acc_write | acc_rmw;
    ea         = acc_addr;
    next_pview = 1'b0;
    next_upper = 1'b0;
    addr_err   = 1'b0;
    stk_err    = 1'b0;
    if (acc_push)
      ea = software_stack_pointer;                         // R15
    else if (acc_pop)
      ea = software_stack_pointer - `PDSG_STK_STEP;        // R15
    if (acc_push | acc_pop)
    begin
      if (ea < `PDSG_STK_FLOOR)
        stk_err = 1'b1;                                    // R20
      if (acc_push && ea > stack_limit_value)
        stk_err = 1'b1;                                    // R19
    end
    if (!win)
      next_addr = {`PDSG_BASE_TOP, ea};                    // R7 R14
    else if (page_sel == 10'h000)
    begin
      next_addr = {`PDSG_BASE_TOP, ea};
      addr_err  = 1'b1;                                    // R6
    end
    else if (is_rd && page_sel[`PDSG_RD_PVIEW_BIT])
    begin
      // program view: one spare top bit, 8-bit page, 15-bit offset
      next_addr  = {1'b0, page_sel[7:0], ea[14:0]};        // R3 R22
      next_pview = 1'b1;
      next_upper = page_sel[`PDSG_RD_UPPER_BIT];           // R22
    end
    else
      next_addr = {page_sel[8:0], ea[14:0]};               // R2 R4 R5
    if (acc_pc_call)
      next_wdata = {8'h00, pc_high_byte};                  // R16
    else if (acc_pc_exc)
      next_wdata = {status_low_byte, pc_high_byte};        // R17
    else
      next_wdata = acc_wdata;
    if (!(win && is_rd))
      cycles = `PDSG_CYC_PLAIN;                            // R11
    else if (acc_repeat && rpt_cnt >= `PDSG_RPT_HEAD_CNT)
      cycles = `PDSG_CYC_PLAIN;                            // R10
    else if (acc_repeat)
      cycles = `PDSG_CYC_RPT_HEAD;                         // R10
    else
      cycles = `PDSG_CYC_WIN_RD;                           // R9
  end

  // access sequencer
  always @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      state              <= ST_IDLE;
      wait_cnt           <= 2'd0;
      rpt_cnt            <= 2'd0;
      acc_done           <= 1'b0;
      acc_fault          <= 1'b0;
      mem_valid          <= 1'b0;
      mem_write          <= 1'b0;
      mem_rmw            <= 1'b0;
      mem_addr           <= 24'h000000;
      mem_wdata          <= 16'h0000;
      mem_program_view   <= 1'b0;
      mem_program_upper  <= 1'b0;
      trap_address_error <= 1'b0;
      trap_stack_error   <= 1'b0;
    end
    else
    begin
      acc_done           <= 1'b0;
      acc_fault          <= 1'b0;
      mem_valid          <= 1'b0;
      trap_address_error <= 1'b0;
      trap_stack_error   <= 1'b0;
      case (state)
        ST_IDLE:
        begin
          if (take)
          begin
            mem_addr          <= next_addr;
            mem_wdata         <= next_wdata;
            mem_write         <= acc_write;
            mem_rmw           <= acc_rmw;
            mem_program_view  <= next_pview;
            mem_program_upper <= next_upper;
            if (!acc_repeat)
              rpt_cnt <= 2'd0;
            else if (win && is_rd && rpt_cnt < `PDSG_RPT_HEAD_CNT)
              rpt_cnt <= rpt_cnt + 2'd1;                   // R10
            if (addr_err | stk_err)
            begin
              // faulting access never reaches memory
              trap_address_error <= addr_err;              // R23
              trap_stack_error   <= stk_err;               // R23
              acc_fault          <= 1'b1;
              acc_done           <= 1'b1;
            end
            else
            begin
              mem_valid <= 1'b1;
              if (cycles == `PDSG_CYC_PLAIN)
                acc_done <= 1'b1;                          // R11
              else
              begin
                state    <= ST_BUSY;
                wait_cnt <= cycles - 2'd2;                 // R9 R10
              end
            end
          end
        end
        ST_BUSY:
        begin
          if (wait_cnt == 2'd0)
          begin
            acc_done <= 1'b1;
            state    <= ST_IDLE;
          end
          else
            wait_cnt <= wait_cnt - 2'd1;
        end
        default:
          state <= ST_IDLE;
      endcase
    end
  end

  // limit is left unreset on purpose; software must load it first
  always @(posedge clk_sys)
  begin
    if (do_bus_wr && aw_addr == `PDSG_OFS_STK_LIMIT)
      stack_limit_value <= new_lim[15:0];                  // R18
  end

  // register slave and stack pointer
  always @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      read_page_select       <= `PDSG_RST_RD_PAGE;
      write_page_select      <= `PDSG_RST_WR_PAGE;
      software_stack_pointer <= `PDSG_RST_STK_PTR;
      aw_full      <= 1'b0;
      aw_addr      <= 8'h00;
      w_full       <= 1'b0;
      w_data       <= 32'h00000000;
      w_strb       <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `PDSG_RESP_OKAY;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp  <= `PDSG_RESP_OKAY;
      s_axi_rdata  <= 32'h00000000;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_full <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_full <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
      // pages change only here, never on pointer wrap
      if (do_bus_wr)
      begin
        aw_full      <= 1'b0;
        w_full       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= `PDSG_RESP_OKAY;
        case (aw_addr)
          `PDSG_OFS_RD_PAGE:
            read_page_select <= new_rd_page[9:0];          // R8
          `PDSG_OFS_WR_PAGE:
            write_page_select <= new_wr_page[8:0];         // R8
          `PDSG_OFS_STK_LIMIT,
          `PDSG_OFS_STATUS:
            s_axi_bresp <= `PDSG_RESP_OKAY;
          `PDSG_OFS_STK_PTR:
            s_axi_bresp <= `PDSG_RESP_OKAY;
          default:
            s_axi_bresp <= `PDSG_RESP_SLVERR;
        endcase
      end
      // cpu stack moves win over a same-cycle bus write of the pointer
      if (take && !addr_err && !stk_err && acc_push)
        software_stack_pointer <= software_stack_pointer
                                  + `PDSG_STK_STEP;        // R15
      else if (take && !addr_err && !stk_err && acc_pop)
        software_stack_pointer <= ea;                      // R15
      else if (do_bus_wr && aw_addr == `PDSG_OFS_STK_PTR)
        software_stack_pointer <= new_sp[15:0];
      if (s_axi_rvalid && s_axi_rready)
        s_axi_rvalid <= 1'b0;
      if (rd_take)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= `PDSG_RESP_OKAY;
        case (s_axi_araddr)
          `PDSG_OFS_RD_PAGE:
            s_axi_rdata <= {22'h0, read_page_select};
          `PDSG_OFS_WR_PAGE:
            s_axi_rdata <= {23'h0, write_page_select};
          `PDSG_OFS_STK_LIMIT:
            s_axi_rdata <= {16'h0, stack_limit_value[15:1], 1'b0}; // R18
          `PDSG_OFS_STK_PTR:
            s_axi_rdata <= {16'h0, software_stack_pointer};
          `PDSG_OFS_STATUS:
            s_axi_rdata <= {28'h0, rpt_cnt, wait_cnt[0], state[1]};
          default:
          begin
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `PDSG_RESP_SLVERR;
          end
        endcase
      end
    end
  end

endmodule

/* File: pdsg_mem_model.sv */
// Purpose: data memory behind the guard, counts accesses
// Assumes: each access is a one-cycle mem_valid pulse
// Notes:   no read data path, the guard returns none
`timescale 1ns/1ps
module pdsg_mem_model
(
  input  wire        clk_sys,
  input  wire        mem_valid,
  input  wire        mem_write,
  input  wire [23:0] mem_addr,
  input  wire [15:0] mem_wdata,
  output reg  [15:0] hits
);
  reg [15:0] store [0:255];
  initial hits = 16'h0000;
  always @(posedge clk_sys)
  begin
    if (mem_valid)
    begin
      hits <= hits + 16'h0001;
      if (mem_write)
        store[mem_addr[8:1]] <= mem_wdata;
    end
  end
endmodule

/* File: pdsg_checker.sv */
// Purpose: port checks of the paged address and stack guard
// Assumes: one clock, traps and done are one-cycle pulses
// Notes:   bound to every pdsg_guard
`timescale 1ns/1ps
module pdsg_checker
(
  input wire        clk_sys,
  input wire        rst_b,
  input wire        acc_valid,
  input wire        acc_ready,
  input wire        acc_write,
  input wire        acc_rmw,
  input wire        acc_repeat,
  input wire        acc_push,
  input wire        acc_pop,
  input wire        acc_pc_call,
  input wire        acc_pc_exc,
  input wire [15:0] acc_addr,
  input wire [7:0]  pc_high_byte,
  input wire [7:0]  status_low_byte,
  input wire        acc_done,
  input wire        acc_fault,
  input wire        mem_valid,
  input wire [23:0] mem_addr,
  input wire [15:0] mem_wdata,
  input wire        trap_address_error,
  input wire        trap_stack_error
);
  wire take = acc_valid && acc_ready;
  wire stk  = acc_push || acc_pop;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  sequence s_win_rd;
    !acc_done ##1 acc_done;
  endsequence
  sequence s_faulted;
    acc_done && acc_fault && !mem_valid;
  endsequence
  property p_low_map;
    take && !stk && !acc_addr[15]
      |=> mem_valid && mem_addr == {8'h00, $past(acc_addr)};
  endproperty
  property p_win_bits;
    take && !stk && acc_addr[15]
      |=> trap_address_error || mem_addr[14:0] == $past(acc_addr[14:0]);
  endproperty
  property p_win_rd;
    take && !stk && !acc_write && acc_addr[15] && !acc_repeat
      |=> trap_address_error or s_win_rd;
  endproperty
  property p_wr_one;
    take && acc_write && !acc_rmw |=> acc_done;
  endproperty
  property p_addr_trap;
    trap_address_error
      |-> s_faulted ##1 (!trap_address_error || $past(take));
  endproperty
  property p_stk_trap;
    trap_stack_error
      |-> s_faulted ##1 (!trap_stack_error || $past(take));
  endproperty
  property p_call;
    take && acc_pc_call
      |=> trap_stack_error || mem_wdata == {8'h00, $past(pc_high_byte)};
  endproperty
  property p_exc;
    take && acc_pc_exc |=> trap_stack_error
      || mem_wdata == {$past(status_low_byte), $past(pc_high_byte)};
  endproperty
  property p_stk_src;
    take && !stk |=> !trap_stack_error;
  endproperty
  a_low_map: assert property (p_low_map)
    else $error("low address not mapped straight");
  a_win_bits: assert property (p_win_bits)
    else $error("window offset bits wrong");
  a_win_rd: assert property (p_win_rd)
    else $error("window read not two cycles");
  a_wr_one: assert property (p_wr_one)
    else $error("write not done in one cycle");
  a_addr_trap: assert property (p_addr_trap)
    else $error("address trap not a faulted pulse");
  a_stk_trap: assert property (p_stk_trap)
    else $error("stack trap not a faulted pulse");
  a_call: assert property (p_call)
    else $error("call push top byte not clear");
  a_exc: assert property (p_exc)
    else $error("exception push word wrong");
  a_stk_src: assert property (p_stk_src)
    else $error("stack trap without stack access");
endmodule
bind pdsg_guard pdsg_checker pdsg_checker_i (.*);

/* File: pdsg_tb.sv */
// Purpose: self-checking bench for the paged address and stack guard
// Assumes: 125 MHz clock, one bus transfer at a time
// Notes:   access latency counted in edges after the take edge
`timescale 1ns/1ps
`include "pdsg_defs.vh"
module testbench;
  reg         clk_sys, rst_b, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
  reg         s_axi_arvalid, s_axi_rready, acc_valid, acc_write, acc_rmw;
  reg         acc_repeat, acc_push, acc_pop, acc_pc_call, acc_pc_exc, t_a;
  reg         t_s, done;
  reg  [1:0]  m_kind;
  reg  [7:0]  s_axi_awaddr, s_axi_araddr, pc_high_byte, status_low_byte;
  reg  [31:0] s_axi_wdata, m_addr, m_data;
  reg  [3:0]  s_axi_wstrb;
  reg  [15:0] acc_addr, acc_wdata, h;
  wire        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  wire        s_axi_rvalid, acc_ready, acc_done, acc_fault, mem_valid;
  wire        mem_write, mem_rmw, mem_program_view, mem_program_upper;
  wire        trap_address_error, trap_stack_error;
  wire [1:0]  s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire [23:0] mem_addr;
  wire [15:0] mem_wdata, hits;
  integer     miscompares, checks, n, lat, i;
  localparam [6:0] f_rd = 7'h00, f_wr = 7'h01, f_rmw = 7'h02, f_rpt = 7'h04;
  localparam [6:0] f_psh = 7'h09, f_pop = 7'h10, f_call = 7'h29;
  localparam [6:0] f_exc = 7'h49;
  localparam [1:0] ok = `PDSG_RESP_OKAY, er = `PDSG_RESP_SLVERR;
  pdsg_guard pdsg_guard_i (.*);
  pdsg_mem_model pdsg_mem_model_i
  (
    .clk_sys(clk_sys), .mem_valid(mem_valid), .mem_write(mem_write),
    .mem_addr(mem_addr), .mem_wdata(mem_wdata), .hits(hits)
  );
  initial
  begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end
  task conclude;
  begin
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  end
  endtask
  task chk(input [31:0] g, input [31:0] e);
  begin
    checks = checks + 1;
    if (g !== e)
    begin
      miscompares = miscompares + 1;
      $display("unexpected at %0t: got %h expected %h", $time, g, e);
    end
  end
  endtask
  task bound;
  begin
    if (!done)
    begin
      miscompares = miscompares + 1;
      conclude;
    end
  end
  endtask
  task wr(input [7:0] a, input [31:0] d, input [1:0] r);
  begin
    done = 1'b0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    for (n = 0; n < 40 && !done; n = n + 1)
    begin
      @(posedge clk_sys);
      if (s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wready)
        s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid === 1'b1)
      begin
        done = 1'b1;
        chk(s_axi_bresp, r);
      end
    end
    bound;
  end
  endtask
  task rd(input [7:0] a, input [31:0] e, input [1:0] r);
  begin
    done = 1'b0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    for (n = 0; n < 40 && !done; n = n + 1)
    begin
      @(posedge clk_sys);
      if (s_axi_arready)
        s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid === 1'b1)
      begin
        done = 1'b1;
        chk(s_axi_rdata, e);
        chk(s_axi_rresp, r);
      end
    end
    bound;
  end
  endtask
  // flags: exc, call, pop, push, repeat, rmw, write
  task ac(input [6:0] f, input [15:0] a, input [15:0] d, input [31:0] ea,
    input [1:0] tr, input integer el);
  begin
    done = 1'b0;
    {acc_pc_exc, acc_pc_call, acc_pop, acc_push, acc_repeat, acc_rmw,
      acc_write} <= f;
    acc_addr <= a;
    acc_wdata <= d;
    acc_valid <= 1'b1;
    for (n = 0; n < 20 && !done; n = n + 1)
    begin
      @(posedge clk_sys);
      done = acc_ready === 1'b1;
    end
    bound;
    acc_valid <= 1'b0;
    done = 1'b0;
    for (lat = 0; lat < 6 && !done; lat = lat + 1)
    begin
      @(posedge clk_sys);
      if (lat == 0)
      begin
        m_addr = {mem_program_view, mem_program_upper, mem_addr};
        m_data = mem_wdata;
        m_kind = {mem_rmw, mem_write};
        t_a = trap_address_error;
        t_s = trap_stack_error;
      end
      done = acc_done === 1'b1;
    end
    bound;
    chk(lat, el);
    chk({t_s, t_a}, tr);
    if (tr == 2'b00)
      chk(m_addr, ea);
    if (tr == 2'b00)
      chk(m_kind, f[1:0]);
  end
  endtask
  task t_regs;
  begin
    rd(`PDSG_OFS_RD_PAGE, 32'h1, ok);
    rd(`PDSG_OFS_WR_PAGE, 32'h1, ok);
    rd(`PDSG_OFS_STK_PTR, 32'h800, ok);
    rd(`PDSG_OFS_STATUS, 32'h0, ok);
    wr(8'h20, 32'hFFFF, er);
    rd(8'h20, 32'h0, er);
    wr(`PDSG_OFS_STK_LIMIT, 32'h901, ok);
    rd(`PDSG_OFS_STK_LIMIT, 32'h900, ok);
    $display("regs test done");
  end
  endtask
  task t_map;
  begin
    wr(`PDSG_OFS_RD_PAGE, 32'h5, ok);
    wr(`PDSG_OFS_WR_PAGE, 32'h3, ok);
    ac(f_rd, 16'h1234, 16'h0, 32'h1234, 2'b00, 1);
    ac(f_rd, 16'h8006, 16'h0, 32'h28006, 2'b00, 2);
    ac(f_wr, 16'hFFFE, 16'hBEEF, 32'h1FFFE, 2'b00, 1);
    chk(m_data, 32'hBEEF);
    ac(f_rmw, 16'h8002, 16'h0, 32'h28002, 2'b00, 2);
    rd(`PDSG_OFS_WR_PAGE, 32'h3, ok);
    wr(`PDSG_OFS_RD_PAGE, 32'h305, ok);
    ac(f_rd, 16'h8010, 16'h0, 32'h3028010, 2'b00, 2);
    ac(f_wr, 16'h8004, 16'h0, 32'h18004, 2'b00, 1);
    $display("map test done");
  end
  endtask
  task t_trap;
  begin
    wr(`PDSG_OFS_RD_PAGE, 32'h0, ok);
    wr(`PDSG_OFS_WR_PAGE, 32'h0, ok);
    h = hits;
    ac(f_rd, 16'h8000, 16'h0, 32'h0, 2'b01, 1);
    ac(f_wr, 16'hC000, 16'h0, 32'h0, 2'b01, 1);
    @(posedge clk_sys);
    chk(hits, h);
    ac(f_rd, 16'h7FFE, 16'h0, 32'h7FFE, 2'b00, 1);
    $display("trap test done");
  end
  endtask
  task t_rpt;
  begin
    wr(`PDSG_OFS_RD_PAGE, 32'h1, ok);
    // plain reads only under repeat, read-modify-write is not allowed
    for (i = 0; i < 4; i = i + 1)
      ac(f_rpt, 16'h8000 + i * 2, 16'h0, 32'h8000 + i * 2, 2'b00,
        (i < 2) ? 3 : 1);
    rd(`PDSG_OFS_STATUS, 32'h8, ok);
    ac(f_rd, 16'h8100, 16'h0, 32'h8100, 2'b00, 2);
    $display("repeat test done");
  end
  endtask
  task t_stack;
  begin
    pc_high_byte <= 8'hAB;
    status_low_byte <= 8'h5C;
    // limit written and acknowledged before the first stack access
    wr(`PDSG_OFS_STK_LIMIT, 32'h804, ok);
    ac(f_call, 16'h0, 16'h0, 32'h800, 2'b00, 1);
    chk(m_data, 32'hAB);
    ac(f_exc, 16'h0, 16'h0, 32'h802, 2'b00, 1);
    chk(m_data, 32'h5CAB);
    ac(f_psh, 16'h0, 16'h1111, 32'h804, 2'b00, 1);
    ac(f_psh, 16'h0, 16'h2222, 32'h0, 2'b10, 1);
    rd(`PDSG_OFS_STK_PTR, 32'h806, ok);
    ac(f_pop, 16'h0, 16'h0, 32'h804, 2'b00, 1);
    ac(f_pop, 16'h0, 16'h0, 32'h802, 2'b00, 1);
    ac(f_pop, 16'h0, 16'h0, 32'h800, 2'b00, 1);
    ac(f_pop, 16'h0, 16'h0, 32'h0, 2'b10, 1);
    rd(`PDSG_OFS_STK_PTR, 32'h800, ok);
    $display("stack test done");
  end
  endtask
  initial
  begin
    miscompares = 0;
    checks = 0;
    rst_b = 1'b0;
    {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid, s_axi_bready,
      s_axi_araddr, s_axi_arvalid, s_axi_rready, acc_valid, acc_write,
      acc_rmw, acc_repeat, acc_push, acc_pop, acc_pc_call, acc_pc_exc,
      acc_addr, acc_wdata, pc_high_byte, status_low_byte} = 0;
    s_axi_wstrb = 4'hF;
    s_axi_bready = 1'b1;
    s_axi_rready = 1'b1;
    repeat (4) @(posedge clk_sys);
    rst_b <= 1'b1;
    @(posedge clk_sys);
    t_regs;
    t_map;
    t_trap;
    t_rpt;
    t_stack;
    conclude;
  end
endmodule
